// [core/mis_pkg.sv]
// Package for the instruction execute block: operation codes, widths, constants.
// Assumes a single clock domain and a host that presents decoded operations.
package mis_pkg;
	// Data and address widths
	localparam int MIS_DW = 8;
	localparam int MIS_PCW = 11;
	localparam int MIS_MEMW = 7;
	localparam int MIS_SLW = 3;
	// Fixed values
	localparam logic [7:0] MIS_ONE = 8'h01;
	localparam logic [7:0] MIS_ALL_ONES = 8'hFF;
	localparam logic [7:0] MIS_ZERO = 8'h00;
	localparam logic [10:0] MIS_PC_STEP = 11'h001;
	localparam logic [2:0] MIS_PTR_STEP = 3'h1;
	// Bit positions
	localparam int MIS_MSB = 7;
	localparam int MIS_NIB = 4;
	// Reset values
	localparam logic [7:0] MIS_ACC_RST = 8'h00;
	localparam logic [10:0] MIS_PC_RST = 11'h000;
	// Operation codes presented on the command port
	typedef enum logic [4:0] {
		MIS_OP_IDLE_INSTRUCTION,
		MIS_OP_INCREMENT_TO_ACC,
		MIS_OP_JUMP_ABSOLUTE,
		MIS_OP_COPY_MEM_TO_ACC,
		MIS_OP_COPY_IMM_TO_ACC,
		MIS_OP_COPY_ACC_TO_MEM,
		MIS_OP_DISJ_MEM_TO_ACC,
		MIS_OP_DISJ_IMM_TO_ACC,
		MIS_OP_DISJUNCTION_INTO_MEM,
		MIS_OP_SUBROUTINE_EXIT,
		MIS_OP_SUBROUTINE_EXIT_LOAD_ACC,
		MIS_OP_INTERRUPT_EXIT,
		MIS_OP_ROTATE_LEFT,
		MIS_OP_ROTATE_LEFT_TO_ACC,
		MIS_OP_ROTATE_LEFT_VIA_CARRY,
		MIS_OP_ROTATE_LEFT_VIA_CARRY_TO_ACC,
		MIS_OP_ROTATE_RIGHT,
		MIS_OP_ROTATE_RIGHT_TO_ACC,
		MIS_OP_ROTATE_RIGHT_VIA_CARRY,
		MIS_OP_ROTATE_RIGHT_VIA_CARRY_TO_ACC,
		MIS_OP_SUBTRACT_WITH_BORROW,
		MIS_OP_SUBTRACT_WITH_BORROW_TO_MEM,
		MIS_OP_DECREMENT_SKIP_IF_ZERO,
		MIS_OP_DECREMENT_TO_ACC_SKIP_IF_ZERO,
		MIS_OP_SET_BYTE,
		MIS_OP_SET_BIT,
		MIS_OP_INCREMENT_SKIP_IF_ZERO,
		MIS_OP_INCREMENT_TO_ACC_SKIP_IF_ZERO
	} mis_op_t;
	// Execution phase
	typedef enum logic [1:0] {
		MIS_ST_EXEC,
		MIS_ST_DUMMY
	} mis_state_t;
endpackage

// [core/mis_core.sv]
// Instruction execute block: applies one decoded operation per instruction cycle
// to the accumulator, data memory, status flags, program counter and stack.
// Assumes the host presents one operation at a time, holding it while o_ready is low.
// Notes on behaviour
// - Memory plus one into accumulator, zero flag
// - Jump loads counter, two cycles, no flags
// - Copies between memory, immediate, accumulator; flags kept
// - Idle instruction changes nothing, counter advances
// - OR with memory or immediate, zero flag
// - Subroutine exit pops counter from stack
// - Exit also loads immediate into accumulator
// - Interrupt exit pops counter, sets global enable
// - Rotate left, bit seven into bit zero
// - Rotate left through carry, only carry changes
// - Rotate right, bit zero into bit seven
// - Rotate right through carry, only carry changes
// - Subtract memory and inverted carry, four flags
// - Carry is inverted borrow after subtraction
// - Decrement memory in place, skip if zero
// - Memory minus one to accumulator, skip
// - Skipping inserts dummy cycle, two cycles total
// - Byte set writes all ones
// - Bit set forces one selected bit
// - Increment memory in place, skip if zero
// - Memory plus one to accumulator, skip
`timescale 1ns/1ps
module mis_core
	import mis_pkg::*;
#(
	parameter int STACK_DEPTH = 6,
	parameter int MEM_DEPTH = 128
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	// Command port
	input wire logic i_op_valid,
	input wire mis_op_t i_op_code,
	input wire logic [MIS_MEMW-1:0] i_op_addr,
	input wire logic [MIS_DW-1:0] i_op_imm,
	input wire logic [MIS_PCW-1:0] i_op_target,
	input wire logic [MIS_SLW-1:0] i_op_bit,
	output logic o_ready,
	// Interrupt request side
	input wire logic i_irq_pending,
	output logic o_irq_enter,
	// Architectural state view
	output logic [MIS_DW-1:0] o_acc,
	output logic [MIS_PCW-1:0] o_pc,
	output logic o_flag_c,
	output logic o_flag_ac,
	output logic o_flag_z,
	output logic o_flag_ov,
	output logic o_global_irq_enable,
	output logic o_dummy_cycle,
	output logic o_stack_err
);

	localparam int SPW = $clog2(STACK_DEPTH + 1);

	// Register state except data memory and return stack in one packed struct
	typedef struct packed {
		mis_state_t state;
		logic [MIS_DW-1:0] acc;
		logic [MIS_PCW-1:0] pc;
		logic c;
		logic ac;
		logic z;
		logic ov;
		logic gie;
		logic irq_enter;
		logic stack_err;
		logic [SPW-1:0] sp;
	} mis_regs_t;

	mis_regs_t state_reg;
	mis_regs_t state_next;
	// Data memory and return stack
	logic [MIS_DW-1:0] mem_reg [MEM_DEPTH];
	logic [MIS_PCW-1:0] stack_reg [STACK_DEPTH];
	// Memory write request from the combinational stage
	logic mem_we;
	logic [MIS_DW-1:0] mem_wdata;
	// Operand and arithmetic helpers
	logic [MIS_DW-1:0] mem_rd;
	logic [MIS_DW:0] sub_full;
	logic [MIS_NIB:0] sub_low;
	logic [MIS_DW-1:0] sub_res;
	logic [MIS_DW-1:0] inc_res;
	logic [MIS_DW-1:0] dec_res;
	logic [MIS_PCW-1:0] stack_top;

	// Operand read and shared arithmetic
	always_comb begin
		mem_rd = mem_reg[i_op_addr];
		inc_res = mem_rd + MIS_ONE;
		dec_res = mem_rd - MIS_ONE;
		sub_full = {1'b0, state_reg.acc} - {1'b0, mem_rd} - {8'h00, ~state_reg.c};
		sub_low = {1'b0, state_reg.acc[MIS_NIB-1:0]} - {1'b0, mem_rd[MIS_NIB-1:0]}
			- {4'h0, ~state_reg.c};
		sub_res = sub_full[MIS_DW-1:0];
		stack_top = (state_reg.sp == '0) ? MIS_PC_RST : stack_reg[state_reg.sp - SPW'(1)];
	end

	// Ready for a new operation except during an inserted dummy cycle
	assign o_ready = (state_reg.state == MIS_ST_EXEC);

	// Next-state logic for every operation
	always_comb begin
		state_next = state_reg;
		state_next.irq_enter = 1'b0;
		mem_we = 1'b0;
		mem_wdata = mem_rd;
		case (state_reg.state)
			MIS_ST_DUMMY: begin
				// Dummy cycle ends, next instruction executes
				state_next.state = MIS_ST_EXEC;
			end
			MIS_ST_EXEC: begin
				if (i_op_valid) begin
					state_next.pc = state_reg.pc + MIS_PC_STEP;
					case (i_op_code)
						MIS_OP_IDLE_INSTRUCTION: begin
						end
						MIS_OP_INCREMENT_TO_ACC: begin
							state_next.acc = inc_res;
							state_next.z = (inc_res == MIS_ZERO);
						end
						MIS_OP_JUMP_ABSOLUTE: begin
							state_next.pc = i_op_target;
							state_next.state = MIS_ST_DUMMY;
						end
						MIS_OP_COPY_MEM_TO_ACC: begin
							state_next.acc = mem_rd;
						end
						MIS_OP_COPY_IMM_TO_ACC: begin
							state_next.acc = i_op_imm;
						end
						MIS_OP_COPY_ACC_TO_MEM: begin
							mem_we = 1'b1;
							mem_wdata = state_reg.acc;
						end
						MIS_OP_DISJ_MEM_TO_ACC: begin
							state_next.acc = state_reg.acc | mem_rd;
							state_next.z = ((state_reg.acc | mem_rd) == MIS_ZERO);
						end
						MIS_OP_DISJ_IMM_TO_ACC: begin
							state_next.acc = state_reg.acc | i_op_imm;
							state_next.z = ((state_reg.acc | i_op_imm) == MIS_ZERO);
						end
						MIS_OP_DISJUNCTION_INTO_MEM: begin
							mem_we = 1'b1;
							mem_wdata = state_reg.acc | mem_rd;
							state_next.z = ((state_reg.acc | mem_rd) == MIS_ZERO);
						end
						MIS_OP_SUBROUTINE_EXIT: begin
							state_next.pc = stack_top;
							state_next.state = MIS_ST_DUMMY;
						end
						MIS_OP_SUBROUTINE_EXIT_LOAD_ACC: begin
							state_next.pc = stack_top;
							state_next.acc = i_op_imm;
							state_next.state = MIS_ST_DUMMY;
						end
						// Pop, enable, take pending request first
						MIS_OP_INTERRUPT_EXIT: begin
							state_next.pc = stack_top;
							state_next.gie = 1'b1;
							state_next.irq_enter = i_irq_pending;
							state_next.state = MIS_ST_DUMMY;
						end
						MIS_OP_ROTATE_LEFT: begin
							mem_we = 1'b1;
							mem_wdata = {mem_rd[MIS_MSB-1:0], mem_rd[MIS_MSB]};
						end
						MIS_OP_ROTATE_LEFT_TO_ACC: begin
							state_next.acc = {mem_rd[MIS_MSB-1:0], mem_rd[MIS_MSB]};
						end
						MIS_OP_ROTATE_LEFT_VIA_CARRY: begin
							mem_we = 1'b1;
							mem_wdata = {mem_rd[MIS_MSB-1:0], state_reg.c};
							state_next.c = mem_rd[MIS_MSB];
						end
						MIS_OP_ROTATE_LEFT_VIA_CARRY_TO_ACC: begin
							state_next.acc = {mem_rd[MIS_MSB-1:0], state_reg.c};
							state_next.c = mem_rd[MIS_MSB];
						end
						MIS_OP_ROTATE_RIGHT: begin
							mem_we = 1'b1;
							mem_wdata = {mem_rd[0], mem_rd[MIS_MSB:1]};
						end
						MIS_OP_ROTATE_RIGHT_TO_ACC: begin
							state_next.acc = {mem_rd[0], mem_rd[MIS_MSB:1]};
						end
						MIS_OP_ROTATE_RIGHT_VIA_CARRY: begin
							mem_we = 1'b1;
							mem_wdata = {state_reg.c, mem_rd[MIS_MSB:1]};
							state_next.c = mem_rd[0];
						end
						MIS_OP_ROTATE_RIGHT_VIA_CARRY_TO_ACC: begin
							state_next.acc = {state_reg.c, mem_rd[MIS_MSB:1]};
							state_next.c = mem_rd[0];
						end
						// Subtract, result to accumulator or memory
						MIS_OP_SUBTRACT_WITH_BORROW, MIS_OP_SUBTRACT_WITH_BORROW_TO_MEM: begin
							if (i_op_code == MIS_OP_SUBTRACT_WITH_BORROW) begin
								state_next.acc = sub_res;
							end else begin
								mem_we = 1'b1;
								mem_wdata = sub_res;
							end
							state_next.z = (sub_res == MIS_ZERO);
							state_next.ov = (state_reg.acc[MIS_MSB] != mem_rd[MIS_MSB])
								&& (sub_res[MIS_MSB] != state_reg.acc[MIS_MSB]);
							state_next.ac = ~sub_low[MIS_NIB];
							state_next.c = ~sub_full[MIS_DW];
						end
						// Decrement in place, skip on zero
						MIS_OP_DECREMENT_SKIP_IF_ZERO: begin
							mem_we = 1'b1;
							mem_wdata = dec_res;
							if (dec_res == MIS_ZERO) begin
								state_next.pc = state_reg.pc + MIS_PC_STEP + MIS_PC_STEP;
								state_next.state = MIS_ST_DUMMY;
							end
						end
						// Decrement to accumulator, skip on zero
						MIS_OP_DECREMENT_TO_ACC_SKIP_IF_ZERO: begin
							state_next.acc = dec_res;
							if (dec_res == MIS_ZERO) begin
								state_next.pc = state_reg.pc + MIS_PC_STEP + MIS_PC_STEP;
								state_next.state = MIS_ST_DUMMY;
							end
						end
						MIS_OP_SET_BYTE: begin
							mem_we = 1'b1;
							mem_wdata = MIS_ALL_ONES;
						end
						MIS_OP_SET_BIT: begin
							mem_we = 1'b1;
							mem_wdata = mem_rd | (MIS_ONE << i_op_bit);
						end
						// Increment in place, skip on zero
						MIS_OP_INCREMENT_SKIP_IF_ZERO: begin
							mem_we = 1'b1;
							mem_wdata = inc_res;
							if (inc_res == MIS_ZERO) begin
								state_next.pc = state_reg.pc + MIS_PC_STEP + MIS_PC_STEP;
								state_next.state = MIS_ST_DUMMY;
							end
						end
						// Increment to accumulator, skip on zero
						MIS_OP_INCREMENT_TO_ACC_SKIP_IF_ZERO: begin
							state_next.acc = inc_res;
							if (inc_res == MIS_ZERO) begin
								state_next.pc = state_reg.pc + MIS_PC_STEP + MIS_PC_STEP;
								state_next.state = MIS_ST_DUMMY;
							end
						end
						default: begin
						end
					endcase
					// Stack pop bookkeeping for all returns
					if (i_op_code == MIS_OP_SUBROUTINE_EXIT
						|| i_op_code == MIS_OP_SUBROUTINE_EXIT_LOAD_ACC
						|| i_op_code == MIS_OP_INTERRUPT_EXIT) begin
						if (state_reg.sp == '0) begin
							state_next.stack_err = 1'b1;
						end else begin
							state_next.sp = state_reg.sp - SPW'(1);
						end
					end
				end
			end
			default: begin
				state_next.state = MIS_ST_EXEC;
			end
		endcase
	end

	// State register
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_reg <= '{state: MIS_ST_EXEC, acc: MIS_ACC_RST, pc: MIS_PC_RST,
				sp: SPW'(STACK_DEPTH), default: '0};
		end else begin
			state_reg <= state_next;
		end
	end

	// Memory write port, no reset on array contents
	always_ff @(posedge i_ref_clk) begin
		if (mem_we) begin
			mem_reg[i_op_addr] <= mem_wdata;
		end
	end

	// Return stack contents start as a known reset image of zeros
	genvar gi;
	generate
		for (gi = 0; gi < STACK_DEPTH; gi++) begin : g_stack
			always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					stack_reg[gi] <= MIS_PC_RST;
				end else begin
					stack_reg[gi] <= stack_reg[gi];
				end
			end
		end
	endgenerate

	// Outputs from registered state
	assign o_acc = state_reg.acc;
	assign o_pc = state_reg.pc;
	assign o_flag_c = state_reg.c;
	assign o_flag_ac = state_reg.ac;
	assign o_flag_z = state_reg.z;
	assign o_flag_ov = state_reg.ov;
	assign o_global_irq_enable = state_reg.gie;
	assign o_irq_enter = state_reg.irq_enter;
	assign o_dummy_cycle = (state_reg.state == MIS_ST_DUMMY);
	assign o_stack_err = state_reg.stack_err;

endmodule

// [verif/mis_properties.sv]
// Port checker for the execute block.
// Assumes one clock and an async active-high reset.
`timescale 1ns/1ps
module mis_properties
	import mis_pkg::*;
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	// Command side
	input wire logic i_op_valid,
	input wire mis_op_t i_op_code,
	input wire logic [MIS_DW-1:0] i_op_imm,
	input wire logic [MIS_PCW-1:0] i_op_target,
	input wire logic i_irq_pending,
	input wire logic o_ready,
	// State view
	input wire logic o_irq_enter,
	input wire logic [MIS_DW-1:0] o_acc,
	input wire logic [MIS_PCW-1:0] o_pc,
	input wire logic o_flag_c,
	input wire logic o_flag_ac,
	input wire logic o_flag_z,
	input wire logic o_flag_ov,
	input wire logic o_global_irq_enable,
	input wire logic o_dummy_cycle
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	// Accepted operation and flag group
	wire take = i_op_valid && o_ready;
	wire [3:0] flg = {o_flag_c, o_flag_ac, o_flag_z, o_flag_ov};
	AST_JUMP: assert property (take && i_op_code == MIS_OP_JUMP_ABSOLUTE |=>
		o_pc == $past(i_op_target) && o_dummy_cycle && $stable(flg)) else $error("jump wrong");
	AST_DUMMY: assert property (o_dummy_cycle |-> !o_ready ##1 !o_dummy_cycle)
		else $error("dummy cycle wrong");
	AST_IDLE: assert property (take && i_op_code == MIS_OP_IDLE_INSTRUCTION |=>
		$stable(o_acc) && $stable(flg) && o_pc == 11'($past(o_pc) + 11'h001)) else $error("idle");
	AST_COPY: assert property (take && i_op_code == MIS_OP_COPY_IMM_TO_ACC |=>
		o_acc == $past(i_op_imm) && $stable(flg)) else $error("copy wrong");
	AST_INC: assert property (take && i_op_code == MIS_OP_INCREMENT_TO_ACC |=>
		$stable({o_flag_c, o_flag_ac, o_flag_ov}) && o_flag_z == (o_acc == 8'h00)) else $error("inc");
	AST_OR: assert property (take && i_op_code == MIS_OP_DISJ_IMM_TO_ACC |=>
		o_acc == ($past(o_acc) | $past(i_op_imm)) && o_flag_z == (o_acc == 8'h00)) else $error("or");
	AST_EXIT_ACC: assert property (take && i_op_code == MIS_OP_SUBROUTINE_EXIT_LOAD_ACC |=>
		o_acc == $past(i_op_imm) && o_dummy_cycle && $stable(flg)) else $error("exit load");
	AST_IRQ: assert property (take && i_op_code == MIS_OP_INTERRUPT_EXIT |=>
		o_global_irq_enable && o_irq_enter == $past(i_irq_pending) ##1 !o_irq_enter)
		else $error("interrupt exit wrong");
endmodule

// [verif/mis_core_bench.sv]
// Bench for the execute block: ops on the command port against a reference model.
// Assumes the checker is compiled first; memory is read back by copy to acc.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module mis_core_bench
	import mis_pkg::*;
();
	// Design inputs
	logic i_ref_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_op_valid = 1'b0;
	mis_op_t i_op_code = MIS_OP_IDLE_INSTRUCTION;
	logic [6:0] i_op_addr = 7'h00;
	logic [7:0] i_op_imm = 8'h00;
	logic [10:0] i_op_target = 11'h000;
	logic [2:0] i_op_bit = 3'h0;
	logic i_irq_pending = 1'b0;
	// Design outputs
	wire o_ready, o_irq_enter, o_flag_c, o_flag_ac, o_flag_z, o_flag_ov;
	wire o_global_irq_enable, o_dummy_cycle, o_stack_err;
	wire [7:0] o_acc;
	wire [10:0] o_pc;
	wire [4:0] flg = {o_flag_c, o_flag_ac, o_flag_z, o_flag_ov, o_global_irq_enable};
	// Reference state
	logic [7:0] em [128];
	logic [7:0] ea = 8'h00;
	logic [10:0] epc = 11'h000;
	logic ec = 1'b0, eac = 1'b0, ez = 1'b0, eov = 1'b0, eie = 1'b0, ed, eirq;
	logic [7:0] sm [4] = '{8'h07, 8'h00, 8'h01, 8'h7F};
	logic [7:0] sa [4] = '{8'h05, 8'h80, 8'h01, 8'hFF};
	int miscompares = 0;
	int total_checks = 0;
	always #5 i_ref_clk = ~i_ref_clk;
	mis_core dut (.*);
	// Verdict and end of run
	task automatic conclude;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// One operation: wait for ready, drive, model, then compare acc, pc, flags and control
	task automatic op(input mis_op_t c, input logic [6:0] a, input logic [7:0] x = 8'h00,
		input logic [10:0] t = 11'h000, input logic [2:0] b = 3'h0);
		logic [7:0] m;
		logic [7:0] r;
		logic [8:0] d;
		logic [4:0] lo;
		int n;
		n = 0;
		while (o_ready !== 1'b1) begin
			n++;
			if (n > 8) begin
				miscompares++;
				conclude();
			end
			@(negedge i_ref_clk);
		end
		i_op_valid = 1'b1;
		i_op_code = c;
		i_op_addr = a;
		i_op_imm = x;
		i_op_target = t;
		i_op_bit = b;
		m = em[a];
		d = {1'b0, ea} - {1'b0, m} - {8'h00, ~ec};
		lo = {1'b0, ea[3:0]} - {1'b0, m[3:0]} - {4'h0, ~ec};
		ed = 1'b0;
		eirq = 1'b0;
		epc = epc + 11'h001;
		case (c)
			MIS_OP_INCREMENT_TO_ACC, MIS_OP_INCREMENT_SKIP_IF_ZERO,
			MIS_OP_INCREMENT_TO_ACC_SKIP_IF_ZERO: r = m + 8'h01;
			MIS_OP_DECREMENT_SKIP_IF_ZERO, MIS_OP_DECREMENT_TO_ACC_SKIP_IF_ZERO: r = m - 8'h01;
			MIS_OP_COPY_IMM_TO_ACC, MIS_OP_SUBROUTINE_EXIT_LOAD_ACC: r = x;
			MIS_OP_COPY_ACC_TO_MEM: r = ea;
			MIS_OP_DISJ_MEM_TO_ACC, MIS_OP_DISJUNCTION_INTO_MEM: r = ea | m;
			MIS_OP_DISJ_IMM_TO_ACC: r = ea | x;
			MIS_OP_ROTATE_LEFT, MIS_OP_ROTATE_LEFT_TO_ACC: r = {m[6:0], m[7]};
			MIS_OP_ROTATE_LEFT_VIA_CARRY, MIS_OP_ROTATE_LEFT_VIA_CARRY_TO_ACC: r = {m[6:0], ec};
			MIS_OP_ROTATE_RIGHT, MIS_OP_ROTATE_RIGHT_TO_ACC: r = {m[0], m[7:1]};
			MIS_OP_ROTATE_RIGHT_VIA_CARRY, MIS_OP_ROTATE_RIGHT_VIA_CARRY_TO_ACC: r = {ec, m[7:1]};
			MIS_OP_SUBTRACT_WITH_BORROW, MIS_OP_SUBTRACT_WITH_BORROW_TO_MEM: r = d[7:0];
			MIS_OP_SET_BYTE: r = 8'hFF;
			MIS_OP_SET_BIT: r = m | (8'h01 << b);
			default: r = m;
		endcase
		// Flag effects, using the old accumulator and carry
		if (c inside {[MIS_OP_DISJ_MEM_TO_ACC:MIS_OP_DISJUNCTION_INTO_MEM], MIS_OP_INCREMENT_TO_ACC,
			MIS_OP_SUBTRACT_WITH_BORROW, MIS_OP_SUBTRACT_WITH_BORROW_TO_MEM}) ez = (r == 8'h00);
		if (c inside {MIS_OP_SUBTRACT_WITH_BORROW, MIS_OP_SUBTRACT_WITH_BORROW_TO_MEM}) begin
			eov = (ea[7] != m[7]) && (r[7] != ea[7]);
			eac = ~lo[4];
			ec = ~d[8];
		end
		if (c inside {MIS_OP_ROTATE_LEFT_VIA_CARRY, MIS_OP_ROTATE_LEFT_VIA_CARRY_TO_ACC}) ec = m[7];
		if (c inside {MIS_OP_ROTATE_RIGHT_VIA_CARRY, MIS_OP_ROTATE_RIGHT_VIA_CARRY_TO_ACC}) ec = m[0];
		// Result destination
		if (c inside {MIS_OP_COPY_ACC_TO_MEM, MIS_OP_DISJUNCTION_INTO_MEM, MIS_OP_ROTATE_LEFT,
			MIS_OP_ROTATE_LEFT_VIA_CARRY, MIS_OP_ROTATE_RIGHT, MIS_OP_ROTATE_RIGHT_VIA_CARRY,
			MIS_OP_SUBTRACT_WITH_BORROW_TO_MEM, MIS_OP_DECREMENT_SKIP_IF_ZERO, MIS_OP_SET_BYTE,
			MIS_OP_SET_BIT, MIS_OP_INCREMENT_SKIP_IF_ZERO}) em[a] = r;
		else if (!(c inside {MIS_OP_IDLE_INSTRUCTION, MIS_OP_JUMP_ABSOLUTE, MIS_OP_SUBROUTINE_EXIT,
			MIS_OP_INTERRUPT_EXIT})) ea = r;
		// Taken skip, jump and returns add a dummy cycle
		if (c inside {[MIS_OP_DECREMENT_SKIP_IF_ZERO:MIS_OP_DECREMENT_TO_ACC_SKIP_IF_ZERO],
			[MIS_OP_INCREMENT_SKIP_IF_ZERO:MIS_OP_INCREMENT_TO_ACC_SKIP_IF_ZERO]} && r == 8'h00) begin
			epc = epc + 11'h001;
			ed = 1'b1;
		end
		if (c inside {[MIS_OP_SUBROUTINE_EXIT:MIS_OP_INTERRUPT_EXIT], MIS_OP_JUMP_ABSOLUTE}) begin
			epc = (c == MIS_OP_JUMP_ABSOLUTE) ? t : 11'h000;
			ed = 1'b1;
		end
		if (c == MIS_OP_INTERRUPT_EXIT) begin
			eie = 1'b1;
			eirq = i_irq_pending;
		end
		@(posedge i_ref_clk);
		@(negedge i_ref_clk);
		`CHK("acc", ea, o_acc)
		`CHK("pc", epc, o_pc)
		`CHK("flags", {ec, eac, ez, eov, eie}, flg)
		`CHK("ctl", {ed, ~ed, eirq}, {o_dummy_cycle, o_ready, o_irq_enter})
	endtask
	// Memory write through the accumulator
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		op(MIS_OP_COPY_IMM_TO_ACC, 7'h00, v);
		op(MIS_OP_COPY_ACC_TO_MEM, a);
	endtask
	// Main sequence
	initial begin
		repeat (10) @(negedge i_ref_clk);
		i_sys_rst = 1'b0;
		`CHK("rst", {8'h00, 11'h000, 5'h00, 1'b1}, {o_acc, o_pc, flg, o_ready})
		wr(7'h01, 8'h81);
		wr(7'h02, 8'h01);
		wr(7'h03, 8'hFF);
		op(MIS_OP_INCREMENT_TO_ACC, 7'h03);
		op(MIS_OP_DISJ_IMM_TO_ACC, 7'h00, 8'h00);
		op(MIS_OP_COPY_MEM_TO_ACC, 7'h03);
		op(MIS_OP_DISJ_IMM_TO_ACC, 7'h00, 8'h40);
		op(MIS_OP_DISJ_MEM_TO_ACC, 7'h02);
		op(MIS_OP_DISJUNCTION_INTO_MEM, 7'h01);
		// Uneven pattern so every rotate form moves bits and carry both ways
		wr(7'h01, 8'hC3);
		for (int i = 0; i < 8; i++) begin
			op(mis_op_t'(5'h0C + 5'(i)), 7'h01);
			op(MIS_OP_COPY_MEM_TO_ACC, 7'h01);
		end
		for (int i = 0; i < 4; i++) begin
			wr(7'h04, sm[i]);
			op(MIS_OP_COPY_IMM_TO_ACC, 7'h00, sa[i]);
			op(mis_op_t'(5'h14 + {4'h0, i[0]}), 7'h04);
			op(MIS_OP_COPY_MEM_TO_ACC, 7'h04);
		end
		for (int i = 0; i < 8; i++) begin
			wr(7'h05, i[0] ? 8'h05 : (i < 4 ? 8'h01 : 8'hFF));
			op(mis_op_t'(5'h16 + {2'b00, i[2], 1'b0, i[1]}), 7'h05);
			op(MIS_OP_COPY_MEM_TO_ACC, 7'h05);
		end
		op(MIS_OP_SET_BYTE, 7'h06);
		op(MIS_OP_COPY_MEM_TO_ACC, 7'h06);
		wr(7'h07, 8'h10);
		op(MIS_OP_SET_BIT, 7'h07, 8'h00, 11'h000, 3'h7);
		op(MIS_OP_SET_BIT, 7'h07);
		op(MIS_OP_COPY_MEM_TO_ACC, 7'h07);
		op(MIS_OP_IDLE_INSTRUCTION, 7'h07, 8'hAA);
		op(MIS_OP_JUMP_ABSOLUTE, 7'h00, 8'h00, 11'h7FE);
		op(MIS_OP_IDLE_INSTRUCTION, 7'h00);
		op(MIS_OP_IDLE_INSTRUCTION, 7'h00);
		op(MIS_OP_SUBROUTINE_EXIT, 7'h00);
		op(MIS_OP_SUBROUTINE_EXIT_LOAD_ACC, 7'h00, 8'h3C);
		op(MIS_OP_INTERRUPT_EXIT, 7'h00);
		i_irq_pending = 1'b1;
		op(MIS_OP_INTERRUPT_EXIT, 7'h00);
		i_irq_pending = 1'b0;
		op(MIS_OP_IDLE_INSTRUCTION, 7'h00);
		// Two more pops empty the preset stack, a third one underflows
		op(MIS_OP_SUBROUTINE_EXIT, 7'h00);
		op(MIS_OP_SUBROUTINE_EXIT, 7'h00);
		`CHK("stack_err", 1'b0, o_stack_err)
		op(MIS_OP_SUBROUTINE_EXIT_LOAD_ACC, 7'h00, 8'hC5);
		`CHK("stack_err", 1'b1, o_stack_err)
		i_op_valid = 1'b0;
		conclude();
	end
	// Hang guard
	initial begin
		repeat (5000) @(posedge i_ref_clk);
		miscompares++;
		conclude();
	end
endmodule
bind mis_core mis_properties chk (.*);
